// File: src/pdt_pkg.sv
`default_nettype none
package pdt_pkg;

    // ========================================
    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W = 16;

    // ========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_INTERRUPT_STATUS_REG = 8'h08;
    localparam logic [7:0] OFF_INT_EN = 8'h0C;

    // ========================================
    // Field positions
    localparam int unsigned CFG_PRELOAD_LSB = 0;
    localparam int unsigned CFG_RUN_BIT = 16;
    localparam int unsigned INT_WRAP_BIT = 0;

    // ========================================
    // Reset values
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] PRELOAD_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ========================================
    // Timing
    localparam int unsigned CLK_FREQ_HZ = 200_000_000;
    localparam int unsigned TICK_US = 100;
    localparam int unsigned TICK_CYCLES = (CLK_FREQ_HZ / 1_000_000) * TICK_US;

    // ========================================
    // Timer run state
    typedef enum logic [1:0]
    {
        ST_STOP = 2'b01,
        ST_RUN = 2'b10
    } pdt_state_e;

endpackage

`default_nettype wire

// File: src/pdt_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none

module pdt_tick_gen #(
    parameter int unsigned DIV = pdt_pkg::TICK_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Control
    input wire logic restart,
    // Tick out
    output logic tick
);

    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_tick;

    // ========================================
    // Prescaler: one pulse per full interval
    always_comb
    begin
        next_cnt = cnt + W'(1);
        next_tick = 1'b0;
        if (restart)
        begin
            next_cnt = '0;
        end
        else if (cnt == LAST)
        begin
            next_cnt = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end

endmodule

`default_nettype wire

// File: src/pdt_timer.sv
// Summary of operation
// R01: Decrement count once per 100 us tick.
// R02: Enabling loads preload into count, counts down.
// R03: Reset or disable forces count to all ones.
// R04: Preload writable whether running or stopped.
// R05: New preload while running restarts countdown.
// R06: Zero wraps to all ones, keeps counting.
// R07: Wrap sets flag only when enable set.
// R08: Flag sticky, cleared by writing one.
// R09: Prescaled tick; stopped count holds all ones.
`timescale 1ns/10ps
`default_nettype none

module pdt_timer #(
    parameter int unsigned TICK_CYCLES = pdt_pkg::TICK_CYCLES,
    parameter int unsigned ADDR_W = pdt_pkg::ADDR_W
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    // Interrupt
    output logic irq
);

    // ========================================
    // Declarations
    pdt_pkg::pdt_state_e state;
    pdt_pkg::pdt_state_e next_state;
    logic [15:0] timer_preload_field;
    logic [15:0] next_timer_preload_field;
    logic [15:0] timer_count_value;
    logic [15:0] next_timer_count_value;

    // Interrupt state
    logic timer_wrap_flag;
    logic next_timer_wrap_flag;
    logic timer_wrap_int_enable;
    logic next_timer_wrap_int_enable;
    logic next_irq;
    logic [31:0] next_rdata;

    // Prescaler and counter events
    logic tick;
    logic restart;
    logic wrap;
    logic load;

    // Register port decode
    logic cfg_wr;
    logic sts_wr;
    logic en_wr;
    logic [15:0] wr_preload;
    logic wr_run;

    // ========================================
    // Address decode
    // Full decode, unmapped offsets ignored
    always_comb
    begin
        cfg_wr = wr_stb && (addr == ADDR_W'(pdt_pkg::OFF_CFG));
        sts_wr = wr_stb && (addr == ADDR_W'(pdt_pkg::OFF_INTERRUPT_STATUS_REG));
        en_wr = wr_stb && (addr == ADDR_W'(pdt_pkg::OFF_INT_EN));
        wr_preload = wdata[pdt_pkg::CFG_PRELOAD_LSB +: 16];
        wr_run = wdata[pdt_pkg::CFG_RUN_BIT];
    end

    // ========================================
    // Tick prescaler
    // Restarted on every load so the first decrement is a full interval away
    always_comb
    begin
        restart = load || (state == pdt_pkg::ST_STOP); // R09
    end

    pdt_tick_gen #(
        .DIV(TICK_CYCLES)
    )
    u_tick_gen
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .restart(restart),
        .tick(tick)
    );

    // ========================================
    // Preload field, writable in any run state
    always_comb
    begin
        next_timer_preload_field = timer_preload_field;
        if (cfg_wr)
        begin
            next_timer_preload_field = wr_preload; // R04
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timer_preload_field <= pdt_pkg::PRELOAD_RST;
        end
        else
        begin
            timer_preload_field <= next_timer_preload_field;
        end
    end

    // ========================================
    // Counter and run state
    always_comb
    begin
        next_state = state;
        next_timer_count_value = timer_count_value;
        wrap = 1'b0;
        load = 1'b0;
        // Stopped count parks at all ones until enabled
        case (state)
            pdt_pkg::ST_STOP:
            begin
                next_timer_count_value = pdt_pkg::COUNT_ALL_ONES; // R09
                if (cfg_wr && wr_run)
                begin
                    next_state = pdt_pkg::ST_RUN;
                    next_timer_count_value = wr_preload; // R02
                    load = 1'b1;
                end
            end
            pdt_pkg::ST_RUN:
            begin
                // Config writes outrank a tick in the same cycle
                if (cfg_wr && !wr_run)
                begin
                    next_state = pdt_pkg::ST_STOP;
                    next_timer_count_value = pdt_pkg::COUNT_ALL_ONES; // R03
                end
                else if (cfg_wr)
                begin
                    next_timer_count_value = wr_preload; // R05
                    load = 1'b1;
                end
                else if (tick)
                begin
                    // Zero wraps on the next tick, no stop
                    if (timer_count_value == 16'h0000)
                    begin
                        next_timer_count_value = pdt_pkg::COUNT_ALL_ONES; // R06
                        wrap = 1'b1;
                    end
                    else
                    begin
                        next_timer_count_value = timer_count_value - 16'h0001; // R01
                    end
                end
            end
            default:
            begin
                next_state = pdt_pkg::ST_STOP;
                next_timer_count_value = pdt_pkg::COUNT_ALL_ONES;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= pdt_pkg::ST_STOP;
            timer_count_value <= pdt_pkg::COUNT_ALL_ONES; // R03
        end
        else
        begin
            state <= next_state;
            timer_count_value <= next_timer_count_value;
        end
    end

    // ========================================
    // Interrupt enable
    always_comb
    begin
        next_timer_wrap_int_enable = timer_wrap_int_enable;
        if (en_wr)
        begin
            next_timer_wrap_int_enable = wdata[pdt_pkg::INT_WRAP_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timer_wrap_int_enable <= 1'b0;
        end
        else
        begin
            timer_wrap_int_enable <= next_timer_wrap_int_enable;
        end
    end

    // ========================================
    // Sticky wrap flag, write one to clear
    always_comb
    begin
        next_timer_wrap_flag = timer_wrap_flag;
        if (sts_wr && wdata[pdt_pkg::INT_WRAP_BIT])
        begin
            next_timer_wrap_flag = 1'b0; // R08
        end
        // Set after clear so a wrap in the clearing cycle is kept
        if (wrap && timer_wrap_int_enable)
        begin
            next_timer_wrap_flag = 1'b1; // R07
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timer_wrap_flag <= 1'b0;
        end
        else
        begin
            timer_wrap_flag <= next_timer_wrap_flag;
        end
    end

    // ========================================
    // Interrupt line, registered so it never glitches
    always_comb
    begin
        next_irq = next_timer_wrap_flag && next_timer_wrap_int_enable; // R07
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= next_irq;
        end
    end

    // ========================================
    // Read data, valid the cycle after the strobe
    always_comb
    begin
        next_rdata = pdt_pkg::RDATA_RST;
        if (rd_stb)
        begin
            case (addr)
                ADDR_W'(pdt_pkg::OFF_CFG):
                begin
                    next_rdata[pdt_pkg::CFG_PRELOAD_LSB +: 16] = timer_preload_field;
                    next_rdata[pdt_pkg::CFG_RUN_BIT] = (state == pdt_pkg::ST_RUN);
                end
                ADDR_W'(pdt_pkg::OFF_COUNT):
                begin
                    next_rdata[15:0] = timer_count_value;
                end
                ADDR_W'(pdt_pkg::OFF_INTERRUPT_STATUS_REG):
                begin
                    next_rdata[pdt_pkg::INT_WRAP_BIT] = timer_wrap_flag;
                end
                ADDR_W'(pdt_pkg::OFF_INT_EN):
                begin
                    next_rdata[pdt_pkg::INT_WRAP_BIT] = timer_wrap_int_enable;
                end
                // Unmapped offsets read as zero
                default:
                begin
                    next_rdata = pdt_pkg::RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata <= pdt_pkg::RDATA_RST;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// File: verification/pdt_timer_sva.sv
`timescale 1ns/10ps
`default_nettype none
module pdt_timer_chk #(
    parameter int unsigned TICK_CYCLES = 4,
    parameter int unsigned ADDR_W = 8
)
(
    // Clock
    input wire logic ref_clk,
    input wire logic resetn,
    // Bus
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    // Irq
    input wire logic irq
);
    logic run;
    logic ien;
    logic wcfg;
    logic wen;
    logic wie;
    logic wsts;
    logic rcnt;
    assign wcfg = wr_stb && addr == pdt_pkg::OFF_CFG;
    assign wen = wr_stb && addr == pdt_pkg::OFF_INT_EN;
    assign wie = wen && wdata[0];
    assign wsts = wr_stb && addr == pdt_pkg::OFF_INTERRUPT_STATUS_REG;
    assign rcnt = rd_stb && addr == pdt_pkg::OFF_COUNT;
    // ====
    // Shadow of run and enable bits
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            run <= 1'b0;
            ien <= 1'b0;
        end
        else
        begin
            run <= wcfg ? wdata[16] : run;
            ien <= wen ? wdata[0] : ien;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    property p_stop;
        rcnt && !run |=> rdata[15:0] == 16'hFFFF;
    endproperty
    a_stop: assert property (p_stop)
        else $error("count not all ones");
    property p_load;
        wcfg && wdata[16] ##1 rcnt |=> rdata[15:0] == $past(wdata[15:0], 2);
    endproperty
    a_load: assert property (p_load)
        else $error("preload not loaded");
    property p_fall;
        $fell(irq) |-> $past(wr_stb);
    endproperty
    a_fall: assert property (p_fall)
        else $error("irq fell alone");
    property p_rise;
        $rose(irq) |-> $past(run) || $past(wie);
    endproperty
    a_rise: assert property (p_rise)
        else $error("irq rose alone");
    property p_w0;
        wsts && !wdata[0] && irq |=> irq;
    endproperty
    a_w0: assert property (p_w0)
        else $error("zero write cleared");
    property p_w1;
        // A wrap in the clearing cycle wins, so checked while stopped
        wsts && wdata[0] && !run |=> !irq;
    endproperty
    a_w1: assert property (p_w1)
        else $error("flag not cleared");
    property p_mask;
        irq |-> ien;
    endproperty
    a_mask: assert property (p_mask)
        else $error("irq while masked");
    property p_idle;
        !rd_stb |=> rdata == 32'h0000_0000;
    endproperty
    a_idle: assert property (p_idle)
        else $error("rdata not zero");
endmodule
bind pdt_timer pdt_timer_chk #(.TICK_CYCLES(TICK_CYCLES), .ADDR_W(ADDR_W)) i_chk (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq));
`default_nettype wire

// File: verification/periodic_down_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
module periodic_down_timer_test;
    logic ref_clk;
    logic resetn;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [31:0] rdata;
    logic irq;
    logic rd_seen = 1'b0;
    logic [31:0] e;
    logic [15:0] p;
    logic [31:0] exp_q[$];
    int failures = 0;
    int tests_run = 0;
    int i;
    pdt_timer #(.TICK_CYCLES(4), .ADDR_W(8)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .irq(irq));
    // ====
    // Bus cycle; a read queues d as expected data
    task op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        wr_stb <= w;
        rd_stb <= r;
        addr <= a;
        wdata <= d;
        if (r)
            exp_q.push_back(d);
        @(posedge ref_clk);
    endtask
    task idle(input int n);
        repeat (n) op(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    endtask
    task chk(input logic want);
        tests_run++;
        if (irq !== want)
        begin
            failures++;
            $display("BAD %0t irq %b", $time, irq);
        end
    endtask
    task end_sim;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Read data stands in the cycle after the strobe
    always @(posedge ref_clk)
    begin
        if (rd_seen)
        begin
            tests_run++;
            e = exp_q.pop_front();
            if (rdata !== e)
            begin
                failures++;
                $display("BAD %0t rdata %h exp %h", $time, rdata, e);
            end
        end
        rd_seen <= rd_stb;
    end
    initial
    begin
        #20000;
        failures++;
        end_sim;
    end
    initial
    begin
        resetn = 1'b0;
        {wr_stb, rd_stb, addr, wdata} = '0;
        void'($urandom(88667));
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        for (i = 0; i < 5; i++)
            op(1'b0, 1'b1, 8'(i * 4), i == 1 ? 32'h0000_FFFF : 32'h0000_0000);
        op(1'b1, 1'b0, 8'h04, 32'h0000_1234);
        op(1'b1, 1'b0, 8'h00, 32'h0000_1234);
        op(1'b0, 1'b1, 8'h00, 32'h0000_1234);
        op(1'b0, 1'b1, 8'h04, 32'h0000_FFFF);
        for (i = 0; i < 4; i++)
        begin
            p = 16'($urandom);
            op(1'b1, 1'b0, 8'h00, {15'h0, 1'b1, p});
            op(1'b0, 1'b1, 8'h04, {16'h0, p});
        end
        op(1'b0, 1'b1, 8'h00, {15'h0, 1'b1, p});
        op(1'b1, 1'b0, 8'h00, 32'h0000_0002);
        op(1'b0, 1'b1, 8'h04, 32'h0000_FFFF);
        // Wrap masked, then unmasked
        for (i = 0; i < 2; i++)
        begin
            op(1'b1, 1'b0, 8'h0C, 32'(i));
            op(1'b1, 1'b0, 8'h00, 32'h0001_0002);
            op(1'b0, 1'b1, 8'h04, 32'h0000_0002);
            idle(5);
            op(1'b0, 1'b1, 8'h04, 32'h0000_0001);
            idle(3);
            op(1'b0, 1'b1, 8'h04, 32'h0000_0000);
            idle(3);
            op(1'b0, 1'b1, 8'h04, 32'h0000_FFFF);
            op(1'b0, 1'b1, 8'h08, 32'(i));
            chk(i[0]);
        end
        op(1'b1, 1'b0, 8'h00, 32'h0000_0002);
        op(1'b0, 1'b1, 8'h04, 32'h0000_FFFF);
        op(1'b1, 1'b0, 8'h08, 32'h0000_0000);
        op(1'b0, 1'b1, 8'h08, 32'h0000_0001);
        op(1'b1, 1'b0, 8'h08, 32'h0000_0001);
        op(1'b0, 1'b1, 8'h08, 32'h0000_0000);
        chk(1'b0);
        idle(2);
        end_sim;
    end
endmodule
`default_nettype wire
